// ===== src/srd_decoder.sv
`timescale 1ns/1ns
`include "srd_regs.svh"

module srd_decoder
  import srd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        frame_start,
  input  wire logic [8:0]  bitrate_kbps,
  input  wire logic [6:0]  res_len,
  input  wire logic        rd_ack,
  input  wire logic [15:0] rd_data,
  output logic             rd_req,
  output logic      [1:0]  rd_kind,
  output logic      [3:0]  rd_nbits,
  output logic      [14:0] rd_prob,
  output logic      [4:0]  rd_model,
  output logic      [4:0]  rd_nsym,
  output logic      [4:0]  rd_prec,
  output logic             res_valid,
  output logic      [5:0]  res_index,
  output logic      [49:0] res_value,
  output logic             res_last,
  output logic             frame_done,
  output logic             busy
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic         rst_meta_ff;
  logic         rst_sync_n;
  srd_state_t   state_ff;
  logic [6:0]   len_ff;
  logic         force_zero_ff;
  logic [6:0]   gidx_ff;
  logic [3:0]   blk_ff;
  logic [2:0]   pos_ff;
  logic [3:0]   param_ff;
  logic [3:0]   left0_ff;
  logic [3:0]   left1_ff;
  logic [15:0]  hi_ff;
  logic [15:0]  mag_ff;
  logic         neg_ff;
  logic         rd_req_ff;
  srd_rd_kind_t rd_kind_ff;
  logic [3:0]   rd_nbits_ff;
  logic [14:0]  rd_prob_ff;
  logic [4:0]   rd_model_ff;
  logic [4:0]   rd_nsym_ff;
  logic [4:0]   rd_prec_ff;
  logic         res_valid_ff;
  logic [5:0]   res_index_ff;
  logic [49:0]  res_value_ff;
  logic         res_last_ff;
  logic         frame_done_ff;
  logic         busy_ff;
  logic [5:0]   prev_index_ff;
  logic [31:0]  gain_q15;
  logic [6:0]   remain;
  logic [3:0]   blen;
  logic         last_pos;
  logic         last_blk;
  logic [3:0]   shift;
  logic [3:0]   nz_clamp;
  logic [15:0]  lsb_mag;
  logic [6:0]   cur_index;
  logic         lsb_raw;

  // Reciprocal of the remaining total at 14-bit precision, totals 2..8
  function automatic logic [13:0] reciprocal_table(input logic [3:0] t);
    case (t)
      4'h2:    reciprocal_table = 14'h2000;
      4'h3:    reciprocal_table = 14'h1555;
      4'h4:    reciprocal_table = 14'h1000;
      4'h5:    reciprocal_table = 14'h0CCD;
      4'h6:    reciprocal_table = 14'h0AAB;
      4'h7:    reciprocal_table = 14'h0925;
      default: reciprocal_table = 14'h0800;
    endcase
  endfunction

  // ******************************************************************
  // Reset release
  // ******************************************************************

  // Two-stage release so every flop leaves reset on the same edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= `SRD_RST_ZERO;
      rst_sync_n  <= `SRD_RST_ZERO;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_n  <= rst_meta_ff;
    end
  end

  // ******************************************************************
  // Block geometry and element arithmetic
  // ******************************************************************

  // Remaining length decides the size of the current block
  assign remain    = 7'(len_ff - {blk_ff, 3'b000});
  assign blen      = (remain > {3'b000, `SRD_BLK_LEN}) ? `SRD_BLK_LEN : remain[3:0];
  assign last_pos  = (pos_ff == 3'(blen - 4'h1));
  assign last_blk  = (remain <= {3'b000, `SRD_BLK_LEN});
  assign shift     = (param_ff > `SRD_SHIFT_BIAS) ? 4'(param_ff - `SRD_SHIFT_BIAS)
                                                  : 4'h0;
  // A count above the block size would underflow the zero tally
  assign nz_clamp  = ({2'b00, rd_data[1:0]} > blen) ? blen : {2'b00, rd_data[1:0]};
  assign lsb_mag   = 16'(hi_ff << shift) | rd_data;
  assign cur_index = {blk_ff[3:0], pos_ff};
  assign lsb_raw   = (hi_ff != 16'h0000) || (shift > `SRD_RAW_SHIFT_MAX);

  srd_gain_dequant u_gain
  (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .gain_idx   (gidx_ff),
    .gain_q15   (gain_q15)
  );

  // ******************************************************************
  // Decode sequencing
  // ******************************************************************

  // One state per read and per answer; the sequencer never runs ahead
  // of an outstanding read
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_ff      <= ST_IDLE;
      len_ff        <= 7'h00;
      force_zero_ff <= 1'b0;
      gidx_ff       <= 7'h00;
      blk_ff        <= 4'h0;
      pos_ff        <= 3'h0;
      param_ff      <= 4'h0;
      left0_ff      <= 4'h0;
      left1_ff      <= 4'h0;
      hi_ff         <= 16'h0000;
      mag_ff        <= 16'h0000;
      neg_ff        <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (frame_start)
          begin
            len_ff        <= res_len;
            blk_ff        <= 4'h0;
            pos_ff        <= 3'h0;
            force_zero_ff <= (bitrate_kbps < `SRD_RES_MIN_KBPS);
            if (bitrate_kbps >= `SRD_RES_MIN_KBPS)
              state_ff <= ST_GAIN_REQ;
            else
              state_ff <= (res_len == 7'h00) ? ST_DONE : ST_ZERO;
          end
        ST_GAIN_REQ:  state_ff <= ST_GAIN_W;
        ST_GAIN_W:
          if (rd_ack)
          begin
            gidx_ff <= rd_data[6:0];
            if (rd_data[6:0] == `SRD_GAIN_ZERO_IDX || len_ff == 7'h00)
            begin
              force_zero_ff <= (rd_data[6:0] == `SRD_GAIN_ZERO_IDX);
              state_ff      <= (len_ff == 7'h00) ? ST_DONE : ST_ZERO;
            end
            else
              state_ff <= ST_PARAM_REQ;
          end
        ST_PARAM_REQ: state_ff <= ST_PARAM_W;
        ST_PARAM_W:
          if (rd_ack)
          begin
            param_ff <= rd_data[3:0];
            state_ff <= (rd_data[3:0] == 4'h0) ? ST_NZ_REQ : ST_HI_REQ;
          end
        ST_NZ_REQ:    state_ff <= ST_NZ_W;
        ST_NZ_W:
          if (rd_ack)
          begin
            left1_ff <= nz_clamp;
            left0_ff <= 4'(blen - nz_clamp);
            state_ff <= ST_LE_DEC;
          end
        ST_LE_DEC:
        begin
          neg_ff <= 1'b0;
          // Forced zeros spend no bits; a forced nonzero symbol still reads its sign bit
          if (left1_ff == 4'h0)
          begin
            mag_ff   <= 16'h0000;
            state_ff <= ST_VALUE;
          end
          else if (left0_ff == 4'h0)
          begin
            mag_ff   <= 16'h0001;
            state_ff <= ST_SIGN_REQ;
          end
          else
            state_ff <= ST_BIT_REQ;
        end
        ST_BIT_REQ:   state_ff <= ST_BIT_W;
        ST_BIT_W:
          if (rd_ack)
          begin
            mag_ff   <= {15'h0000, rd_data[0]};
            state_ff <= rd_data[0] ? ST_SIGN_REQ : ST_VALUE;
          end
        ST_HI_REQ:    state_ff <= ST_HI_W;
        ST_HI_W:
          if (rd_ack)
          begin
            hi_ff  <= rd_data;
            neg_ff <= 1'b0;
            mag_ff <= rd_data;
            if (shift != 4'h0)
              state_ff <= ST_LSB_REQ;
            else
              state_ff <= (rd_data != 16'h0000) ? ST_SIGN_REQ : ST_VALUE;
          end
        ST_LSB_REQ:   state_ff <= ST_LSB_W;
        ST_LSB_W:
          if (rd_ack)
          begin
            mag_ff   <= lsb_mag;
            state_ff <= (lsb_mag != 16'h0000) ? ST_SIGN_REQ : ST_VALUE;
          end
        ST_SIGN_REQ:  state_ff <= ST_SIGN_W;
        ST_SIGN_W:
          if (rd_ack)
          begin
            neg_ff   <= rd_data[0];
            state_ff <= ST_VALUE;
          end
        ST_VALUE:
        begin
          if (param_ff == 4'h0)
          begin
            if (mag_ff != 16'h0000)
              left1_ff <= 4'(left1_ff - 4'h1);
            else
              left0_ff <= 4'(left0_ff - 4'h1);
          end
          if (last_pos)
          begin
            pos_ff   <= 3'h0;
            blk_ff   <= 4'(blk_ff + 4'h1);
            state_ff <= last_blk ? ST_DONE : ST_PARAM_REQ;
          end
          else
          begin
            pos_ff   <= 3'(pos_ff + 3'h1);
            state_ff <= (param_ff == 4'h0) ? ST_LE_DEC : ST_HI_REQ;
          end
        end
        ST_ZERO:
          if (cur_index == 7'(len_ff - 7'h01))
            state_ff <= ST_DONE;
          else
            {blk_ff, pos_ff} <= 7'(cur_index + 7'h01);
        ST_DONE:      state_ff <= ST_IDLE;
        default:      state_ff <= ST_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // Range decoder reads
  // ******************************************************************

  // Fields are loaded with the request and held until the answer
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rd_req_ff   <= 1'b0;
      rd_kind_ff  <= RD_RAW;
      rd_nbits_ff <= 4'h0;
      rd_prob_ff  <= 15'h0000;
      rd_model_ff <= 5'h00;
      rd_nsym_ff  <= 5'h00;
      rd_prec_ff  <= 5'h00;
    end
    else
    begin
      if (rd_ack)
        rd_req_ff <= 1'b0;
      case (state_ff)
        ST_GAIN_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= RD_RAW;
          rd_nbits_ff <= `SRD_GAIN_BITS;
        end
        ST_PARAM_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= RD_SYMBOL;
          rd_model_ff <= `SRD_MODEL_PARAM;
          rd_nsym_ff  <= `SRD_MODEL_SYMS;
          rd_prec_ff  <= `SRD_PROB_BITS;
        end
        ST_NZ_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= RD_RAW;
          rd_nbits_ff <= `SRD_NZ_BITS;
        end
        ST_BIT_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= RD_BIT_PROB;
          rd_prob_ff  <= 15'(left0_ff * reciprocal_table(4'(left0_ff + left1_ff)));
          rd_prec_ff  <= `SRD_PROB_BITS;
        end
        ST_HI_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= RD_ESCAPE;
          rd_model_ff <= 5'({1'b0, param_ff} - 5'h01);
          rd_nsym_ff  <= `SRD_MODEL_SYMS;
        end
        ST_LSB_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= lsb_raw ? RD_RAW : RD_SYMBOL;
          rd_nbits_ff <= shift;
          rd_model_ff <= 5'(`SRD_MODEL_LSB_BASE + {1'b0, shift});
          rd_nsym_ff  <= 5'(5'h01 << shift);
          rd_prec_ff  <= `SRD_PROB_BITS;
        end
        ST_SIGN_REQ:
        begin
          rd_req_ff   <= 1'b1;
          rd_kind_ff  <= RD_RAW;
          rd_nbits_ff <= 4'h1;
        end
        default:
        begin
        end
      endcase
    end
  end

  // ******************************************************************
  // Residual output towards the inverse transform
  // ******************************************************************

  // Gain is applied here so the transform stage sees final values
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      res_valid_ff  <= 1'b0;
      res_index_ff  <= 6'h00;
      res_value_ff  <= 50'h0;
      res_last_ff   <= 1'b0;
      frame_done_ff <= 1'b0;
      busy_ff       <= 1'b0;
      prev_index_ff <= 6'h00;
    end
    else
    begin
      res_valid_ff  <= (state_ff == ST_VALUE) || (state_ff == ST_ZERO);
      res_index_ff  <= cur_index[5:0];
      frame_done_ff <= (state_ff == ST_DONE);
      busy_ff       <= (state_ff != ST_IDLE) || frame_start;
      if (res_valid_ff)
        prev_index_ff <= res_index_ff;
      if (state_ff == ST_ZERO)
      begin
        res_value_ff <= 50'h0;
        res_last_ff  <= (cur_index == 7'(len_ff - 7'h01));
      end
      else
      begin
        res_value_ff <= 50'($signed(neg_ff ? -{1'b0, mag_ff} : {1'b0, mag_ff})
                        * $signed({1'b0, gain_q15}));
        res_last_ff  <= (state_ff == ST_VALUE) && last_pos && last_blk;
      end
    end
  end

  assign rd_req     = rd_req_ff;
  assign rd_kind    = rd_kind_ff;
  assign rd_nbits   = rd_nbits_ff;
  assign rd_prob    = rd_prob_ff;
  assign rd_model   = rd_model_ff;
  assign rd_nsym    = rd_nsym_ff;
  assign rd_prec    = rd_prec_ff;
  assign res_valid  = res_valid_ff;
  assign res_index  = res_index_ff;
  assign res_value  = res_value_ff;
  assign res_last   = res_last_ff;
  assign frame_done = frame_done_ff;
  assign busy       = busy_ff;

  // ******************************************************************
  // Checks
  // ******************************************************************
  a_low_rate_skip: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (state_ff == ST_IDLE && frame_start && bitrate_kbps < `SRD_RES_MIN_KBPS)
    |=> (state_ff != ST_GAIN_REQ) ##1 !rd_req)
    else $error("residual read started below minimum rate");
  a_zero_output: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_valid && force_zero_ff |-> res_value == 50'h0)
    else $error("forced-zero frame delivered a nonzero value");
  a_gain_read: assert property (@(posedge clock) disable iff (!rst_sync_n)
    state_ff == ST_GAIN_REQ |=> rd_req && rd_kind == RD_RAW && rd_nbits == 4'h7)
    else $error("gain index not read on seven raw bits");
  a_param_model: assert property (@(posedge clock) disable iff (!rst_sync_n)
    state_ff == ST_PARAM_REQ |=> rd_req && rd_kind == RD_SYMBOL
    && rd_nsym == 5'd16 && rd_prec == 5'd14 && rd_model == `SRD_MODEL_PARAM)
    else $error("block parameter read with wrong model");
  a_nz_raw: assert property (@(posedge clock) disable iff (!rst_sync_n)
    state_ff == ST_NZ_REQ |=> rd_req && rd_kind == RD_RAW && rd_nbits == 4'h2)
    else $error("nonzero count not read on two raw bits");
  a_prob_calc: assert property (@(posedge clock) disable iff (!rst_sync_n)
    state_ff == ST_BIT_REQ |=> rd_kind == RD_BIT_PROB && $past(left1_ff) != 4'h0
    && $past(left0_ff) != 4'h0
    && rd_prob == 15'($past(left0_ff) * reciprocal_table(4'($past(left0_ff) + $past(left1_ff)))))
    else $error("binary read issued with wrong zero probability");
  a_sign_apply: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (state_ff == ST_SIGN_W && rd_ack)
    |-> ##2 res_valid && (res_value[49] == $past(rd_data[0], 2)))
    else $error("sign bit not applied to delivered value");
  a_lsb_read: assert property (@(posedge clock) disable iff (!rst_sync_n)
    state_ff == ST_LSB_REQ |=> rd_req && ((rd_kind == RD_RAW) == lsb_raw)
    && (rd_kind != RD_RAW || rd_nbits == shift) && shift != 4'h0)
    else $error("low-order bits read the wrong way");
  a_escape_model: assert property (@(posedge clock) disable iff (!rst_sync_n)
    state_ff == ST_HI_REQ |=> rd_kind == RD_ESCAPE && rd_nsym == 5'd16
    && rd_model == 5'({1'b0, param_ff} - 5'h01))
    else $error("high part read with wrong model");
  a_mag_form: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (state_ff == ST_LSB_W && rd_ack)
    |=> mag_ff == (16'($past(hi_ff) << shift) | $past(rd_data)))
    else $error("magnitude not formed from high part and low bits");
  a_index_step: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_valid && res_index != 6'h00 |-> res_index == 6'(prev_index_ff + 6'h01))
    else $error("residual index skipped a position");
  a_last_index: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_last |-> res_valid && res_index == 6'(len_ff - 7'h01))
    else $error("last value not at vector end");
  a_one_read: assert property (@(posedge clock) disable iff (!rst_sync_n)
    rd_req && !rd_ack |=> rd_req && $stable(rd_kind) && $stable(rd_nbits))
    else $error("read dropped or changed before its answer");

endmodule

// ===== include/srd_regs.svh
`ifndef SRD_REGS_SVH
`define SRD_REGS_SVH

// ********************************************************************
// Residual decoder constants
// ********************************************************************

// Lowest bit rate, in kbps, at which residual coding is active
`define SRD_RES_MIN_KBPS   9'h020
// Gain index width and the index that forces an all-zero residual
`define SRD_GAIN_BITS      4'h7
`define SRD_GAIN_ZERO_IDX  7'h7F
// Gain exponent step 90/(20*127)*log2(10) in Q16
`define SRD_GAIN_K_Q16     20'h01E22
// Block geometry
`define SRD_BLK_LEN        4'h8
`define SRD_NZ_BITS        4'h2
// Model alphabet size and probability precision
`define SRD_MODEL_SYMS     5'h10
`define SRD_PROB_BITS      5'h0E
// Low-order bit split
`define SRD_SHIFT_BIAS     4'h3
`define SRD_RAW_SHIFT_MAX  4'h4
// Model selectors sent upstream: 0x00..0x0E high-part tables,
// 0x10 parameter table, 0x11..0x14 low-bit tables by shift
`define SRD_MODEL_PARAM    5'h10
`define SRD_MODEL_LSB_BASE 5'h10
// Reset values
`define SRD_RST_ZERO       1'b0

`endif

// ===== include/srd_pkg.sv
// ********************************************************************
// Residual decoder types
// ********************************************************************
package srd_pkg;

  // Decode sequencer states
  typedef enum logic [4:0]
  {
    ST_IDLE      = 5'h00,
    ST_GAIN_REQ  = 5'h01,
    ST_GAIN_W    = 5'h02,
    ST_PARAM_REQ = 5'h03,
    ST_PARAM_W   = 5'h04,
    ST_NZ_REQ    = 5'h05,
    ST_NZ_W      = 5'h06,
    ST_LE_DEC    = 5'h07,
    ST_BIT_REQ   = 5'h08,
    ST_BIT_W     = 5'h09,
    ST_HI_REQ    = 5'h0A,
    ST_HI_W      = 5'h0B,
    ST_LSB_REQ   = 5'h0C,
    ST_LSB_W     = 5'h0D,
    ST_SIGN_REQ  = 5'h0E,
    ST_SIGN_W    = 5'h0F,
    ST_VALUE     = 5'h10,
    ST_ZERO      = 5'h11,
    ST_DONE      = 5'h12
  } srd_state_t;

  // Kinds of read asked of the range decoder
  typedef enum logic [1:0]
  {
    RD_RAW      = 2'h0,
    RD_BIT_PROB = 2'h1,
    RD_SYMBOL   = 2'h2,
    RD_ESCAPE   = 2'h3
  } srd_rd_kind_t;

endpackage

// ===== src/srd_gain_dequant.sv
`timescale 1ns/1ns
`include "srd_regs.svh"

// ********************************************************************
// Gain index to linear gain, Q15, one cycle latency
// ********************************************************************
module srd_gain_dequant
  import srd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_sync_n,
  input  wire logic [6:0]  gain_idx,
  output logic      [31:0] gain_q15
);

  logic [19:0] expo;
  logic [3:0]  frac_sel;
  logic [16:0] mant_lo;
  logic [16:0] mant_hi;
  logic [28:0] interp;
  logic [16:0] mant;
  logic [31:0] gain_ff;

  // Two to the power i/16, Q15; linear steps between entries keep the
  // error well under a tenth of a dB, traded against a full ROM
  function automatic logic [16:0] pow2_frac(input logic [4:0] i);
    case (i)
      5'h00: pow2_frac = 17'h08000;
      5'h01: pow2_frac = 17'h085AB;
      5'h02: pow2_frac = 17'h08B96;
      5'h03: pow2_frac = 17'h091C4;
      5'h04: pow2_frac = 17'h09838;
      5'h05: pow2_frac = 17'h09EF5;
      5'h06: pow2_frac = 17'h0A5FF;
      5'h07: pow2_frac = 17'h0AD58;
      5'h08: pow2_frac = 17'h0B505;
      5'h09: pow2_frac = 17'h0BD09;
      5'h0A: pow2_frac = 17'h0C567;
      5'h0B: pow2_frac = 17'h0CE25;
      5'h0C: pow2_frac = 17'h0D745;
      5'h0D: pow2_frac = 17'h0E0CD;
      5'h0E: pow2_frac = 17'h0EAC1;
      5'h0F: pow2_frac = 17'h0F525;
      default: pow2_frac = 17'h10000;
    endcase
  endfunction

  // Exponent in base two, split into shift and interpolated mantissa
  assign expo     = 20'(gain_idx * `SRD_GAIN_K_Q16);
  assign frac_sel = expo[15:12];
  assign mant_lo  = pow2_frac({1'b0, frac_sel});
  assign mant_hi  = pow2_frac(5'({1'b0, frac_sel} + 5'h01));
  assign interp   = 29'((mant_hi - mant_lo) * expo[11:0]);
  assign mant     = 17'(mant_lo + 17'(interp >> 12));

  // Registered result
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gain_ff <= 32'h00000000;
    end
    else
    begin
      gain_ff <= 32'({15'h0000, mant} << expo[19:16]);
    end
  end

  assign gain_q15 = gain_ff;

endmodule

// ===== test/srd_range_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Range decoder stand-in
// ****************************************************************
module srd_range_model
(
  input  wire logic        clock,
  input  wire logic        rd_req,
  output logic             rd_ack,
  output logic      [15:0] rd_data
);
  logic [15:0] script_q[$];
  int          wait_n;
  int          turn_n;
  initial
  begin
    rd_ack = 1'b0;
    rd_data = 16'h0000;
    wait_n = 0;
    turn_n = 0;
  end
  // One read answered at a time, after 0..2 idle cycles
  // Data toggles outside the ack cycle so a stale value never looks valid
  always @(posedge clock)
  begin
    if (rd_req && !rd_ack && script_q.size() > 0 && wait_n == 0)
    begin
      rd_ack <= 1'b1;
      rd_data <= script_q.pop_front();
      turn_n = turn_n + 1;
      wait_n = turn_n % 3;
    end
    else
    begin
      rd_ack <= 1'b0;
      rd_data <= ~rd_data;
      if (rd_req && !rd_ack && script_q.size() > 0)
        wait_n = wait_n - 1;
    end
  end
endmodule

// ===== test/srd_decoder_bench.sv
`timescale 1ns/1ns
module srd_decoder_bench
  import srd_pkg::*;
;
  logic               clock;
  logic               rst_n;
  logic               frame_start;
  logic        [8:0]  bitrate_kbps;
  logic        [6:0]  res_len;
  logic               rd_ack;
  logic        [15:0] rd_data;
  logic               rd_req;
  logic               res_valid;
  logic        [5:0]  res_index;
  logic        [49:0] res_value;
  logic               res_last;
  logic               frame_done;
  logic signed [49:0] exp_v[64];
  int                 failures;
  int                 n_checks;
  int                 n_seen;
  int                 cycles;
  int                 seed;
  logic        [15:0] gidx;
  srd_decoder u_srd_decoder (.clock(clock), .rst_n(rst_n), .frame_start(frame_start),
    .bitrate_kbps(bitrate_kbps), .res_len(res_len), .rd_ack(rd_ack), .rd_data(rd_data),
    .rd_req(rd_req), .rd_kind(), .rd_nbits(), .rd_prob(), .rd_model(), .rd_nsym(),
    .rd_prec(), .res_valid(res_valid), .res_index(res_index), .res_value(res_value),
    .res_last(res_last), .frame_done(frame_done), .busy());
  srd_range_model u_srd_range_model (.clock(clock), .rd_req(rd_req), .rd_ack(rd_ack),
    .rd_data(rd_data));
  task automatic check_val(input string what, input logic [49:0] e, input logic [49:0] g);
    logic [49:0] d;
    d = (e > g) ? e - g : g - e;
    n_checks++;
    // Gain is interpolated, so allow a tenth of a percent
    if (!((d <= (e[49] ? -e : e) / 1000) && (^g !== 1'bx)))
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask
  // Quantised value times ten to the index times 90/(20*127), in Q15
  function automatic logic signed [49:0] scaled(input int idx, input int q);
    real g;
    g = 32768.0 * (10.0 ** (idx * 90.0 / 2540.0));
    scaled = 50'(longint'(q * g));
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Start one frame and wait for its end under a bound
  task automatic run_frame(input logic [8:0] rate, input logic [6:0] n);
    int k;
    n_seen = 0;
    @(negedge clock);
    bitrate_kbps = rate;
    res_len = n;
    frame_start = 1'b1;
    @(negedge clock);
    frame_start = 1'b0;
    for (k = 0; k < 3000 && frame_done !== 1'b1; k++)
      @(negedge clock);
    check_val("count", 50'(n), 50'(n_seen));
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Every output value goes to the position it names
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      failures++;
      tally_and_finish();
    end
    if (res_valid === 1'b1)
    begin
      n_seen++;
      check_val("value", exp_v[res_index], res_value);
      check_val("last", 50'(res_index == 6'(res_len - 1)), 50'(res_last));
    end
  end
  initial
  begin
    rst_n = 1'b0;
    frame_start = 1'b0;
    bitrate_kbps = 9'h000;
    res_len = 7'h00;
    seed = 32'h325d;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    n_seen = 0;
    foreach (exp_v[i])
      exp_v[i] = 50'h0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    // Below the rate threshold nothing is read and all values are zero
    repeat (6)
      run_frame(9'($unsigned($random(seed)) % 32), 7'($unsigned($random(seed)) % 65));
    // Forced-zero gain index with random lengths
    repeat (3)
    begin
      u_srd_range_model.script_q.push_back(16'h007F);
      run_frame(9'h020, 7'($unsigned($random(seed)) % 65));
    end
    // Low-entropy block then short normal block, gain index 0 is unity
    u_srd_range_model.script_q = '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000,
      16'h0005, 16'h0003, 16'h0001, 16'h0001};
    exp_v[0] = scaled(0, 1);
    exp_v[8] = scaled(0, -13);
    run_frame(9'h028, 7'h09);
    // Binary read gives zero then one, modelled low bit, random gain and rate
    gidx = 16'($unsigned($random(seed)) % 127);
    u_srd_range_model.script_q = '{gidx, 16'h0000, 16'h0001, 16'h0000, 16'h0001,
      16'h0001, 16'h0004, 16'h0000, 16'h0001, 16'h0000};
    exp_v[0] = 50'h0;
    exp_v[1] = scaled(gidx, -1);
    exp_v[8] = scaled(gidx, 1);
    run_frame(9'(32 + $unsigned($random(seed)) % 480), 7'h09);
    tally_and_finish();
  end
endmodule
